// *** rtl/fsc_pkg.sv ***
// fifo status flags and configuration: shared constants and types
// assumes a single clock and byte addresses on the register port
package fsc_pkg;

  // ****************************************
  // pointer and storage geometry
  // ****************************************
  localparam int PTR_W = 14;                    // pointer width, one wrap bit above the address
  localparam logic [13:0] DEPTH_MAX = 14'h2000; // entries at the narrowest width
  localparam logic [13:0] FULL_RELEASE = 14'h0002; // free slots seen before full drops
  localparam int DATA_W = 72;                   // widest data path

  // data width codes; capacity halves with each step
  typedef enum logic [2:0] {
    FSC_W4 = 3'b000,
    FSC_W9 = 3'b001,
    FSC_W18 = 3'b010,
    FSC_W36 = 3'b011,
    FSC_W72 = 3'b100
  } fsc_width_e;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] OFF_CFG = 8'h00;  // mode bits and width code
  localparam logic [7:0] OFF_AE = 8'h04;   // almost-empty threshold
  localparam logic [7:0] OFF_AF = 8'h08;   // almost-full threshold
  localparam logic [7:0] OFF_STAT = 8'h0c; // live flags, read only
  localparam logic [7:0] OFF_FILL = 8'h10; // read-side entry count, read only

  // configuration field positions
  localparam int CFG_LA_BIT = 0;    // lookahead output
  localparam int CFG_PIPE_BIT = 1;  // output pipeline register
  localparam int CFG_TIED_BIT = 2;  // tied-clock mode
  localparam int CFG_WSEL_LSB = 4;  // width code, three bits

  // status field positions
  localparam int ST_EMPTY_BIT = 0;
  localparam int ST_LOW_BIT = 1;
  localparam int ST_FULL_BIT = 2;
  localparam int ST_HIGH_BIT = 3;
  localparam int ST_RERR_BIT = 4;
  localparam int ST_WERR_BIT = 5;

  // reset values
  localparam logic LA_RST = 1'b0;
  localparam logic PIPE_RST = 1'b1;
  localparam logic TIED_RST = 1'b0;
  localparam logic [12:0] AE_RST = 13'h0006;
  localparam logic [12:0] AF_RST = 13'h0004;

endpackage

// *** rtl/fsc_sync.sv ***
// fsc_sync: two-stage synchroniser for a gray-coded pointer
// assumes the source changes at most one bit per source edge
`timescale 1ns/1ps
`default_nettype none

module fsc_sync
  import fsc_pkg::*;
#(
  parameter int W = PTR_W // bits carried
) (
  input wire logic clock,          // sampling clock
  input wire logic nrst,           // async reset, active low
  input wire logic [W-1:0] din,    // gray pointer from the far side
  output logic [W-1:0] dout        // settled copy
);

  // ****************************************
  // one two-flop chain per bit
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta; // first stage, read only by the second
      // first stage may go metastable; nothing else looks at it
      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          meta <= 1'b0;
        end else begin
          meta <= din[i];
        end
      end
      // second stage gives the settled level
      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          dout[i] <= 1'b0;
        end else begin
          dout[i] <= meta;
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// *** rtl/fsc_fifo_flags.sv ***
// fsc_fifo_flags: queue with hysteresis warnings, error flags and modes
// assumes requests synchronous to clock; config is static while in use
// Operation
// RULE1: low warning when entries at or below threshold
// RULE2: low warning clears above threshold plus one
// RULE3: lookahead needs threshold at least four times ratio
// RULE4: read on empty ignored, raises read error
// RULE5: read error drops on request low or nonempty
// RULE6: full when no free slots, write pointer frozen
// RULE7: full clears after two reads, delayed
// RULE8: write on full ignored, raises write error
// RULE9: write error drops on request low or nonfull
// RULE10: high warning when free slots at or below threshold
// RULE11: high warning clears above threshold plus one
// RULE12: both thresholds are thirteen-bit static values
// RULE13: lookahead shows first word without a read
// RULE14: pipeline default one, required unless tied; here split sides never use it, only tied mode does
// RULE15: tied mode pipeline adds one read cycle
// RULE16: width selects 4/9/18/36/72, sets capacity
// RULE17: tied mode joins sides, lookahead disabled
// RULE18: empty after last read, read pointer frozen
// RULE19: reset sets empty and low, clears full and high
// RULE20: gray pointers cross through synchronisers
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module fsc_fifo_flags
  import fsc_pkg::*;
(
  input wire logic clock,                  // single clock
  input wire logic nrst,                   // async reset, active low
  input wire logic write_request,          // write one word
  input wire logic [DATA_W-1:0] write_data, // word to store
  input wire logic read_request,           // read one word
  output logic [DATA_W-1:0] read_data,     // word out
  output logic empty_flag,                 // nothing to read
  output logic full_flag,                  // nothing free
  output logic low_fill_warning,           // few entries left
  output logic high_fill_warning,          // few slots left
  output logic read_underflow_flag,        // read tried while empty
  output logic write_overflow_flag,        // write tried while full
  input wire logic [7:0] reg_addr,         // register byte address
  input wire logic [31:0] reg_wdata,       // register write data
  input wire logic reg_write,              // write strobe
  input wire logic reg_read,               // read strobe
  output logic [31:0] reg_rdata            // read data, cycle after strobe
);

  // ****************************************
  // configuration state
  // ****************************************
  logic la_cfg;          // lookahead output requested
  logic pipe_cfg;        // output pipeline register
  logic tied_cfg;        // tied-clock mode
  fsc_width_e wsel;      // width code
  logic [12:0] ae_thr;   // almost-empty threshold
  logic [12:0] af_thr;   // almost-full threshold
  logic la_on;           // lookahead as actually applied
  logic pipe_on;         // extra data stage in use

  // ****************************************
  // pointer and count signals
  // ****************************************
  logic [13:0] cap, pmask;              // capacity and pointer wrap mask
  logic [12:0] amask;                   // address mask
  logic [13:0] wptr, rptr;              // binary pointers
  logic [13:0] wgray, rgray;            // gray copies sent across
  logic [13:0] wgray_s, rgray_s;        // synchronised gray copies
  logic [13:0] rptr_w, wptr_r;          // far pointer as each side sees it
  logic [13:0] wfill, wfill_n, free_n;  // write-side view
  logic [13:0] rfill, rfill_n;          // read-side view
  logic [13:0] entries_n;               // entries incl. the lookahead word
  logic wtake, rtake;                   // pointer moves this cycle
  logic out_valid, next_out_valid;      // lookahead word held
  logic next_empty;                     // empty for the next edge
  logic [DATA_W-1:0] mem [0:8191];      // storage, width 72 at most
  logic [DATA_W-1:0] fetch_word;        // word at the read address
  logic [DATA_W-1:0] stage;             // first data stage
  logic [DATA_W-1:0] wmask;             // active bits for the width

  // gray to binary, walking down from the top bit
  function automatic logic [13:0] gray2bin(input logic [13:0] g);
    logic [13:0] b;
    b[13] = g[13];
    for (int i = 12; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // ****************************************
  // register port
  // ****************************************
  // mode bits; an illegal width code is dropped, the old width stays
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      la_cfg <= LA_RST;
      pipe_cfg <= PIPE_RST;
      tied_cfg <= TIED_RST;
      wsel <= FSC_W4;
    end else if (reg_write && reg_addr == OFF_CFG) begin
      la_cfg <= reg_wdata[CFG_LA_BIT];
      pipe_cfg <= reg_wdata[CFG_PIPE_BIT];
      tied_cfg <= reg_wdata[CFG_TIED_BIT];
      if (reg_wdata[CFG_WSEL_LSB+:3] <= FSC_W72) begin
        wsel <= fsc_width_e'(reg_wdata[CFG_WSEL_LSB+:3]);
      end
    end
  end

  // RULE12 thirteen-bit thresholds
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ae_thr <= AE_RST;
      af_thr <= AF_RST;
    end else if (reg_write) begin
      if (reg_addr == OFF_AE) begin
        ae_thr <= reg_wdata[12:0];
      end
      if (reg_addr == OFF_AF) begin
        af_thr <= reg_wdata[12:0];
      end
    end
  end

  // read data only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h0;
    end else if (reg_read) begin
      case (reg_addr)
        OFF_CFG: reg_rdata <= {25'h0, wsel, 1'b0, tied_cfg, pipe_cfg, la_cfg};
        OFF_AE: reg_rdata <= {19'h0, ae_thr};
        OFF_AF: reg_rdata <= {19'h0, af_thr};
        OFF_STAT: reg_rdata <= {26'h0, write_overflow_flag, read_underflow_flag,
                                high_fill_warning, full_flag, low_fill_warning, empty_flag};
        OFF_FILL: reg_rdata <= {18'h0, entries_n};
        default: reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // ****************************************
  // mode and geometry decode
  // ****************************************
  // RULE17 tied mode forbids lookahead
  assign la_on = la_cfg & ~tied_cfg;
  // RULE14 split sides never use the pipeline; the bit only matters when tied
  assign pipe_on = tied_cfg & pipe_cfg;

  // RULE16 capacity halves per width step
  always_comb begin
    cap = DEPTH_MAX >> wsel;
    pmask = {cap[12:0], 1'b0} - 14'h0001;
    amask = cap[12:0] - 13'h0001;
    case (wsel)
      FSC_W4: wmask = {68'h0, 4'hf};
      FSC_W9: wmask = {63'h0, 9'h1ff};
      FSC_W18: wmask = {54'h0, 18'h3ffff};
      FSC_W36: wmask = {36'h0, 36'hf_ffff_ffff};
      default: wmask = {72{1'b1}};
    endcase
  end

  // ****************************************
  // pointer crossing
  // ****************************************
  // RULE20 gray pointers pass two flops; wrap keeps one-bit steps
  fsc_sync #(.W(PTR_W)) u_wsync (
    .clock(clock),
    .nrst(nrst),
    .din(wgray),
    .dout(wgray_s)
  );
  fsc_sync #(.W(PTR_W)) u_rsync (
    .clock(clock),
    .nrst(nrst),
    .din(rgray),
    .dout(rgray_s)
  );

  // tied mode skips the crossing: flags then carry no extra latency
  assign rptr_w = tied_cfg ? rptr : gray2bin(rgray_s);
  assign wptr_r = tied_cfg ? wptr : gray2bin(wgray_s);

  // ****************************************
  // write side
  // ****************************************
  always_comb begin
    wfill = (wptr - rptr_w) & pmask;
    // RULE8 a write while full is not taken
    wtake = write_request & ~full_flag;
    wfill_n = wfill + {13'h0, wtake};
    free_n = cap - wfill_n;
  end

  // RULE6 pointer moves only on a taken write
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wptr <= 14'h0;
      wgray <= 14'h0;
    end else if (wtake) begin
      wptr <= (wptr + 14'h0001) & pmask;
      wgray <= ((wptr + 14'h0001) & pmask) ^ (((wptr + 14'h0001) & pmask) >> 1);
    end
  end

  // storage is not reset; contents survive reset
  always_ff @(posedge clock) begin
    if (wtake) begin
      mem[wptr[12:0] & amask] <= write_data & wmask;
    end
  end

  // RULE19 full cleared at reset
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      full_flag <= 1'b0;
    end else if (full_flag) begin
      // RULE7 hold full until two slots are seen free
      full_flag <= free_n < FULL_RELEASE;
    end else begin
      // RULE6 full as the last slot fills
      full_flag <= free_n == 14'h0;
    end
  end

  // RULE10 high warning at or below threshold
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      high_fill_warning <= 1'b0;
    end else if (free_n <= {1'b0, af_thr}) begin
      high_fill_warning <= 1'b1;
    end else if (free_n > {1'b0, af_thr} + 14'h0001) begin
      // RULE11 clear only past threshold plus one
      high_fill_warning <= 1'b0;
    end
  end

  // RULE9 error follows the request while full persists
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      write_overflow_flag <= 1'b0;
    end else begin
      write_overflow_flag <= write_request & full_flag;
    end
  end

  // ****************************************
  // read side
  // ****************************************
  always_comb begin
    rfill = (wptr_r - rptr) & pmask;
    if (la_on) begin
      // RULE13 fetch by itself when the output word is absent
      rtake = (rfill != 14'h0) & (~out_valid | read_request);
      next_out_valid = rtake | (out_valid & ~read_request);
      rfill_n = rfill - {13'h0, rtake};
      next_empty = ~next_out_valid;
    end else begin
      // RULE4 a read while empty is not taken
      rtake = read_request & ~empty_flag;
      next_out_valid = 1'b0;
      rfill_n = rfill - {13'h0, rtake};
      // RULE18 empty as the last entry leaves
      next_empty = rfill_n == 14'h0;
    end
    entries_n = rfill_n + {13'h0, next_out_valid};
    fetch_word = mem[rptr[12:0] & amask];
  end

  // RULE18 read pointer frozen unless a word is taken
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rptr <= 14'h0;
      rgray <= 14'h0;
    end else if (rtake) begin
      rptr <= (rptr + 14'h0001) & pmask;
      rgray <= ((rptr + 14'h0001) & pmask) ^ (((rptr + 14'h0001) & pmask) >> 1);
    end
  end

  // RULE19 empty set at reset
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      empty_flag <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      empty_flag <= next_empty;
      out_valid <= next_out_valid;
    end
  end

  // RULE1 low warning at or below threshold; set at reset
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      low_fill_warning <= 1'b1;
    end else if (entries_n <= {1'b0, ae_thr}) begin
      low_fill_warning <= 1'b1;
    end else if (entries_n > {1'b0, ae_thr} + 14'h0001) begin
      // RULE2 clear only past threshold plus one
      low_fill_warning <= 1'b0;
    end
  end

  // RULE5 error follows the request while empty persists
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      read_underflow_flag <= 1'b0;
    end else begin
      read_underflow_flag <= read_request & empty_flag;
    end
  end

  // RULE15 data stage; the output register reads it when the pipeline is on
  // data stage is kept over reset on purpose, as the storage is; the output register clears
  always_ff @(posedge clock) begin
    if (rtake) begin
      stage <= fetch_word;
    end
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      read_data <= '0;
    end else if (pipe_on) begin
      read_data <= stage;
    end else if (rtake) begin
      read_data <= fetch_word;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  rd_frozen_a: assert property (!la_on && empty_flag |=> $stable(rptr)) // RULE4
    else $error("read pointer moved while empty");
  rerr_set_a: assert property (read_request && empty_flag |=> read_underflow_flag) // RULE4
    else $error("read error missing");
  rerr_drop_a: assert property (!read_request || !empty_flag |=> !read_underflow_flag) // RULE5
    else $error("read error did not drop");
  wr_frozen_a: assert property (full_flag && write_request |=> $stable(wptr)) // RULE6
    else $error("write pointer moved while full");
  werr_set_a: assert property (write_request && full_flag |=> write_overflow_flag) // RULE8
    else $error("write error missing");
  werr_drop_a: assert property (!write_request || !full_flag |=> !write_overflow_flag) // RULE9
    else $error("write error did not drop");
  full_set_a: assert property (!full_flag && free_n == 14'h0 |=> full_flag) // RULE6
    else $error("full not raised");
  full_hold_a: assert property (full_flag && free_n < FULL_RELEASE |=> full_flag) // RULE7
    else $error("full dropped early");
  low_set_a: assert property (entries_n <= {1'b0, ae_thr} |=> low_fill_warning) // RULE1
    else $error("low warning missing");
  low_clear_a: assert property (entries_n > {1'b0, ae_thr} + 14'h0001 |=> !low_fill_warning) // RULE2
    else $error("low warning stuck");
  high_set_a: assert property (free_n <= {1'b0, af_thr} |=> high_fill_warning) // RULE10
    else $error("high warning missing");
  high_clear_a: assert property (free_n > {1'b0, af_thr} + 14'h0001 |=> !high_fill_warning) // RULE11
    else $error("high warning stuck");
  look_show_a: assert property (la_on && !out_valid && rfill != 14'h0 |=> !empty_flag) // RULE13
    else $error("lookahead word not shown");
  pipe_delay_a: assert property (pipe_on && rtake |-> ##2 read_data == $past(fetch_word, 2)) // RULE15
    else $error("pipeline data latency wrong");
  // a word must never be fetched on its own while the sides are tied
  tied_look_a: assert property (tied_cfg && la_cfg |=> !out_valid) // RULE17
    else $error("lookahead active in tied mode");

  fill_up_c: cover property (!full_flag ##1 full_flag);
  drain_c: cover property (!empty_flag && read_request ##1 empty_flag);
  look_c: cover property (la_on && empty_flag ##1 !empty_flag);
  errs_c: cover property (read_underflow_flag ##[1:20] write_overflow_flag);

endmodule
`default_nettype wire

// *** verif/fsc_user_model.sv ***
// fsc_user_model: user writer and user reader on the far side of the queue
// assumes the bench gives one command per clock, changed just after the edge
`timescale 1ns/1ps
`default_nettype none

module fsc_user_model (
  input wire logic clock, // shared clock
  input wire logic nrst, // async reset, active low
  input wire logic wr_go, // bench wants a write next cycle
  input wire logic [71:0] wr_word, // word to write
  input wire logic rd_go, // bench wants a read next cycle
  input wire logic abuse, // ignore the flags on purpose
  input wire logic full_flag, // queue full
  input wire logic empty_flag, // queue empty
  output logic write_request, // write strobe to the queue
  output logic [71:0] write_data, // word to the queue
  output logic read_request // read strobe to the queue
);
  logic wr_q; // registered write wish
  logic rd_q; // registered read wish

  // ****************************************
  // request generation
  // ****************************************
  // requests stay low in reset, as the queue expects
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      write_data <= 72'h0;
    end else begin
      wr_q <= wr_go;
      rd_q <= rd_go;
      // idle line toggles so a stale word never passes for a fresh one
      if (wr_go) begin
        write_data <= wr_word;
      end else begin
        write_data <= ~write_data;
      end
    end
  end

  // a polite user gates on the live flags; abuse is how errors are provoked
  assign write_request = wr_q & (abuse | ~full_flag);
  assign read_request = rd_q & (abuse | ~empty_flag);
endmodule
`default_nettype wire

// *** verif/tb_fsc_fifo_flags.sv ***
// tb_fsc_fifo_flags: self-checking bench for the queue flags and modes
// assumes the user model as writer and reader, both on the one clock
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fail_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb_fsc_fifo_flags import fsc_pkg::*;;
  logic clock = 1'b0; // 250 MHz
  logic nrst = 1'b0; // async reset, active low
  logic wr_go = 1'b0, rd_go = 1'b0, abuse = 1'b0; // model commands
  logic [71:0] wr_word = 72'h0; // next word for the model
  logic write_request, read_request; // model requests
  logic [71:0] write_data, read_data; // data in and out
  logic empty_flag, full_flag, low_fill_warning, high_fill_warning;
  logic read_underflow_flag, write_overflow_flag;
  logic [7:0] reg_addr = 8'h00; // register port
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic reg_write = 1'b0, reg_read = 1'b0;
  int fail_count = 0;
  int tests_run = 0;
  int ov_cnt = 0, un_cnt = 0; // cycles with an error flag up
  logic [31:0] seed = 32'h65bb; // xorshift state
  logic [31:0] exp_reg[$]; // expected register reads
  logic [71:0] exp_dat[$], model_q[$], wbuf; // expected words, queue image
  logic rv = 1'b0, d1 = 1'b0, d2 = 1'b0; // result-due pipeline
  logic pipe_lat = 1'b0, la = 1'b0; // current data latency and lookahead
  logic [71:0] dmask = {72{1'b1}}; // bits the queue keeps at the current width

  always #2 clock = ~clock;

  fsc_fifo_flags i_fsc_fifo_flags (.clock(clock), .nrst(nrst),
    .write_request(write_request), .write_data(write_data), .read_request(read_request),
    .read_data(read_data), .empty_flag(empty_flag), .full_flag(full_flag),
    .low_fill_warning(low_fill_warning), .high_fill_warning(high_fill_warning),
    .read_underflow_flag(read_underflow_flag), .write_overflow_flag(write_overflow_flag),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata));

  fsc_user_model i_fsc_user_model (.clock(clock), .nrst(nrst), .wr_go(wr_go),
    .wr_word(wr_word), .rd_go(rd_go), .abuse(abuse), .full_flag(full_flag),
    .empty_flag(empty_flag), .write_request(write_request), .write_data(write_data),
    .read_request(read_request));

  // ****************************************
  // result watcher
  // ****************************************
  // pre-edge values are sampled, so a due result is the one standing now
  always @(posedge clock) begin
    if (rv) `CHK(reg_rdata, exp_reg.pop_front())
    if (pipe_lat ? d2 : d1) `CHK(read_data, exp_dat.pop_front())
    d2 = d1;
    d1 = read_request & ~empty_flag & ~la;
    rv = reg_read;
    if (write_overflow_flag === 1'b1) ov_cnt++;
    if (read_underflow_flag === 1'b1) un_cnt++;
    if (write_request & ~full_flag) model_q.push_back(write_data & dmask);
    if (read_request & ~empty_flag) begin
      wbuf = model_q.pop_front();
      // lookahead words are checked by the main sequence
      if (!la) exp_dat.push_back(wbuf);
    end
  end

  // ****************************************
  // drivers and helpers
  // ****************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // stored bits for a width code: 4, 9, 18, 36 or 72
  function automatic int wbits(input logic [2:0] code);
    case (code)
      3'h0: return 4;
      3'h1: return 9;
      3'h2: return 18;
      3'h3: return 36;
      default: return 72;
    endcase
  endfunction

  task automatic test_done();
    if (fail_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    reg_read <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    reg_write <= 1'b0;
    exp_reg.push_back(e);
  endtask

  // nw writes and nr reads side by side, then a settle gap
  task automatic feed(input int nw, input int nr, input logic ab);
    for (int i = 0; i < nw || i < nr; i++) begin
      @(posedge clock);
      seed = xs(seed);
      wr_word <= {seed[7:0], seed, ~seed};
      wr_go <= (i < nw);
      rd_go <= (i < nr);
      abuse <= ab;
      reg_write <= 1'b0;
      reg_read <= 1'b0;
    end
    @(posedge clock);
    wr_go <= 1'b0;
    rd_go <= 1'b0;
    repeat (4) @(posedge clock);
    #1;
  endtask

  // bounded wait for the empty flag
  task automatic wait_empty(input logic v);
    int n;
    n = 0;
    while (empty_flag !== v && n < 100) begin
      @(posedge clock);
      n++;
    end
    if (empty_flag !== v) begin
      fail_count++;
      test_done();
    end
  endtask

  // ****************************************
  // fill to full, then drain to empty
  // ****************************************
  task automatic fill_drain(input logic [31:0] cfg, input int cap);
    int c0;
    reg_wr(OFF_CFG, cfg);
    feed(0, 1, 1'b0);
    pipe_lat = cfg[CFG_PIPE_BIT];
    // narrow widths drop the upper data bits
    dmask = {72{1'b1}} >> (72 - wbits(cfg[CFG_WSEL_LSB+:3]));
    feed(7, 0, 1'b0);
    `CHK(low_fill_warning, 1'b1)
    feed(1, 0, 1'b0);
    `CHK(low_fill_warning, 1'b0)
    feed(cap - 8, 0, 1'b0);
    `CHK({full_flag, high_fill_warning}, 2'b11)
    c0 = ov_cnt;
    feed(3, 0, 1'b1);
    `CHK(ov_cnt - c0, 3)
    `CHK(write_overflow_flag, 1'b0)
    reg_rd(OFF_FILL, 32'(cap));
    feed(0, 1, 1'b0);
    `CHK(full_flag, 1'b1)
    feed(0, 1, 1'b0);
    `CHK({full_flag, high_fill_warning}, 2'b01)
    feed(0, 3, 1'b0);
    `CHK(high_fill_warning, 1'b1)
    feed(0, 1, 1'b0);
    `CHK(high_fill_warning, 1'b0)
    feed(0, cap - 13, 1'b0);
    `CHK(low_fill_warning, 1'b0)
    feed(0, 1, 1'b0);
    `CHK(low_fill_warning, 1'b1)
    feed(0, 6, 1'b0);
    `CHK(empty_flag, 1'b1)
    c0 = un_cnt;
    feed(0, 3, 1'b1);
    `CHK(un_cnt - c0, 3)
    `CHK(read_underflow_flag, 1'b0)
    reg_rd(OFF_FILL, 32'h0);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge clock);
    #1;
    `CHK({empty_flag, low_fill_warning, full_flag, high_fill_warning}, 4'b1100)
    @(posedge clock);
    nrst <= 1'b1;
    reg_rd(OFF_CFG, 32'h2);
    reg_rd(OFF_AE, {19'h0, AE_RST});
    reg_rd(OFF_AF, {19'h0, AF_RST});
    reg_rd(OFF_STAT, 32'h3);
    reg_rd(8'h14, 32'h0);
    reg_wr(OFF_AE, 32'hffff_ffff);
    reg_rd(OFF_AE, 32'h1fff);
    reg_wr(OFF_AE, 32'h6);
    for (int c = 0; c < 5; c++) begin
      reg_wr(OFF_CFG, 32'h2 | (32'(c) << 4));
      reg_rd(OFF_CFG, 32'h2 | (32'(c) << 4));
    end
    reg_wr(OFF_CFG, 32'h52);
    reg_rd(OFF_CFG, 32'h42);
    fill_drain(32'h44, 512);
    fill_drain(32'h36, 1024);
    // threshold six covers one clock ratio
    reg_wr(OFF_CFG, 32'h43);
    feed(0, 1, 1'b0);
    dmask = {72{1'b1}};
    la = 1'b1;
    feed(1, 0, 1'b0);
    wait_empty(1'b0);
    #1;
    `CHK(read_data, model_q[0])
    feed(0, 1, 1'b0);
    wait_empty(1'b1);
    reg_rd(OFF_FILL, 32'h0);
    feed(0, 1, 1'b0);
    // tied mode with lookahead asked for: the word waits for a read
    reg_wr(OFF_CFG, 32'h47);
    feed(0, 1, 1'b0);
    la = 1'b0;
    pipe_lat = 1'b1;
    feed(1, 0, 1'b0);
    `CHK(read_data == model_q[0], 1'b0)
    feed(0, 1, 1'b0);
    `CHK(empty_flag, 1'b1)
    test_done();
  end
endmodule
`default_nettype wire
